// ==== pkg/rgd_pkg.sv ====
// Constants shared by the reset generation block
package rgd_pkg;

  // Clock and slow oscillator timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int RC_PERIOD_NS   = 31250;
  localparam int RC_DIV_CYC     = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int POR_UNIT_TICKS = 4096;
  localparam int FACTOR_W       = 7;

  // Reset line stretch length in clock cycles
  localparam logic [4:0] PULSE_CYC = 5'h10;

  // Register byte offsets
  localparam logic [7:0] OFS_SYSCTRL = 8'h00;
  localparam logic [7:0] OFS_PMUCTRL = 8'h04;
  localparam logic [7:0] OFS_PORPIN  = 8'h08;
  localparam logic [7:0] OFS_PORTIME = 8'h0C;
  localparam logic [7:0] OFS_RSTSTAT = 8'h10;
  localparam logic [7:0] OFS_GPDATA  = 8'h14;
  localparam logic [7:0] OFS_SCRATCH = 8'h18;

  // Field positions
  localparam int SYS_SWRB_BIT = 0;
  localparam int PMU_WAKE_BIT = 0;
  localparam int PIN_SEL_LSB  = 0;
  localparam int PIN_SEL_W    = 4;
  localparam int PIN_POL_BIT  = 4;
  localparam int STAT_POR_BIT = 0;
  localparam int STAT_HW_BIT  = 1;
  localparam int STAT_SW_BIT  = 2;

  // Values after reset
  localparam logic [FACTOR_W-1:0] PORTIME_RST = 7'h18;
  localparam logic [2:0]          STAT_RST    = 3'h1;
  localparam logic [3:0]          PINSEL_RST  = 4'h0;
  localparam logic [31:0]         WORD_RST    = 32'h0000_0000;

endpackage : rgd_pkg

// ==== hw/rgd_rst_sync.sv ====
// Reset synchroniser: asynchronous assert, clocked release
module rgd_rst_sync (
  input  wire logic clk,
  input  wire logic rst_in_n,
  output logic      rst_out_n
);

  logic meta_r;
  logic hold_r;

  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      meta_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      hold_r <= meta_r;
    end
  end

  assign rst_out_n = hold_r;

endmodule : rgd_rst_sync

// ==== hw/rgd_por_timer.sv ====
// Long-press counter for the power-on sources
module rgd_por_timer
  import rgd_pkg::*;
#(
  parameter int UNIT = POR_UNIT_TICKS
)(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                tick,
  input  wire logic                pad_act,
  input  wire logic                gpio_act,
  input  wire logic [FACTOR_W-1:0] factor,
  output logic                     expire,
  output logic                     short_rel
);

  localparam int CW = FACTOR_W + $clog2(UNIT) + 1;

  logic [CW-1:0] cnt_r,   cnt_nxt;
  logic          spent_r, spent_nxt;
  logic          pad_d_r;
  logic          exp_r,   sh_r;
  logic [CW-1:0] limit;
  logic          live, run, hit, sh_nxt;

  assign limit = CW'(factor) * CW'(UNIT);

  always_comb begin
    live      = pad_act & ~spent_r;
    run       = live | gpio_act;
    hit       = run & tick & ((cnt_r + CW'(1)) >= limit);
    cnt_nxt   = !run ? '0 : (tick ? (hit ? '0 : cnt_r + CW'(1)) : cnt_r);
    spent_nxt = !pad_act ? 1'b0 : (spent_r | (hit & live));
    sh_nxt    = pad_d_r & ~pad_act & ~spent_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= '0;
      spent_r <= 1'b0;
      pad_d_r <= 1'b0;
      exp_r   <= 1'b0;
      sh_r    <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      spent_r <= spent_nxt;
      pad_d_r <= pad_act;
      exp_r   <= hit;
      sh_r    <= sh_nxt;
    end
  end

  assign expire    = exp_r;
  assign short_rel = sh_r;

  a_pad_once: assert property (@(posedge clk) disable iff (!rst_n)
    (spent_r && !gpio_act) |=> !expire)
    else $error("pad expiry repeated within one press");

  a_cnt_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (!pad_act && !gpio_act) |=> (cnt_r == '0))
    else $error("counter not cleared after release");

endmodule : rgd_por_timer

// ==== hw/rgd_top.sv ====
// Reset generation: sources, timer, cause latch, reset domains, APB registers
//
// Implementation choices: the APB interface to the registers and the address map.

module rgd_top
  import rgd_pkg::*;
#(
  parameter int POR_UNIT = POR_UNIT_TICKS,
  parameter int RC_DIV   = RC_DIV_CYC,
  parameter int NGPIO    = 12
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             vdd_ok,
  input  wire logic             vbat_high_ok,
  input  wire logic             vbat_low_ok,
  input  wire logic             port0_pin0,
  input  wire logic [NGPIO-1:0] gpio_in,
  input  wire logic             cpu_sys_reset_req,
  input  wire logic             wake_from_sleep,
  output logic                  rst_por_n,
  output logic                  rst_hw_n,
  output logic                  rst_all_n,
  output logic                  cold_boot
);

  generate
    if (NGPIO < 1 || NGPIO > 16) begin : g_chk_gpio
      $error("NGPIO must be 1 to 16");
    end
    if (RC_DIV < 1 || RC_DIV > 65536) begin : g_chk_div
      $error("RC_DIV must be 1 to 65536");
    end
    if (POR_UNIT < 1) begin : g_chk_unit
      $error("POR_UNIT must be at least 1");
    end
  endgenerate

  // Slow oscillator tick divider
  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic        tick;

  always_comb begin
    tick    = (div_r == 16'(RC_DIV - 1));
    div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Registers, grouped by the reset that reaches them
  logic [PIN_SEL_W-1:0] pin_sel_r;
  logic [PIN_SEL_W-1:0] pin_sel_nxt;
  logic                 pin_pol_r;
  logic                 pin_pol_nxt;
  logic [FACTOR_W-1:0]  por_fac_r;
  logic [FACTOR_W-1:0]  por_fac_nxt;
  logic [31:0]          gp_data_r;
  logic [31:0]          gp_data_nxt;
  logic [2:0]           stat_r;
  logic [2:0]           stat_nxt;
  logic                 swrb_r;
  logic                 swrb_nxt;
  logic                 wake_en_r;
  logic                 wake_en_nxt;
  logic [31:0]          scratch_r;
  logic [31:0]          scratch_nxt;

  // Bus decode
  logic        wr;
  logic        setup_rd;
  logic        hit;
  logic [31:0] rd_val;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // Source handling
  logic       pad_act;
  logic       gpio_act;
  logic       tmr_exp;
  logic       tmr_short;
  logic       supply_ok;
  logic [2:0] req;
  logic [2:0] act_r;
  logic [2:0] act_nxt;
  logic [2:0] ev;
  logic [2:0] dom_n;
  logic       boot_d_r;
  logic       cold_boot_r;

  // high level on the pad is a request
  assign pad_act = port0_pin0;

  always_comb begin
    gpio_act = 1'b0;
    if (pin_sel_r != PINSEL_RST && 32'(pin_sel_r) < NGPIO) begin
      gpio_act = ~(gpio_in[pin_sel_r] ^ pin_pol_r);
    end
  end

  // long assertion of pad or GPIO
  rgd_por_timer #(
    .UNIT      (POR_UNIT)
  ) u_timer (
    .clk       (pclk),
    .rst_n     (presetn),
    .tick      (tick),
    .pad_act   (pad_act),
    .gpio_act  (gpio_act),
    .factor    (por_fac_r),
    .expire    (tmr_exp),
    .short_rel (tmr_short)
  );

  assign supply_ok = vdd_ok & vbat_high_ok & vbat_low_ok;

  always_comb begin
    req[0] = tmr_exp;
    req[1] = tmr_short | (wake_from_sleep & wake_en_r);
    req[2] = swrb_r | cpu_sys_reset_req;
  end

  // Lines are nested: domain i is reset by lines 0..i
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_line
      logic [4:0] cnt_r;
      logic [4:0] cnt_nxt;
      logic       sync_in_n;

      always_comb begin
        cnt_nxt     = req[gi] ? PULSE_CYC : (cnt_r != 5'h00 ? cnt_r - 5'h01 : 5'h00);
        act_nxt[gi] = req[gi] | (cnt_r > 5'h01);
        ev[gi]      = act_nxt[gi] & ~act_r[gi];
      end

      // Stretch keeps a short request from giving a runt reset
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r      <= 5'h00;
          act_r[gi]  <= 1'b0;
        end else begin
          cnt_r      <= cnt_nxt;
          act_r[gi]  <= act_nxt[gi];
        end
      end

      assign sync_in_n = presetn & supply_ok & ~(|act_r[gi:0]);

      rgd_rst_sync u_sync (
        .clk       (pclk),
        .rst_in_n  (sync_in_n),
        .rst_out_n (dom_n[gi])
      );
    end
  endgenerate

  assign rst_por_n = dom_n[0];
  assign rst_hw_n  = dom_n[1];
  assign rst_all_n = dom_n[2];

  // cold boot after power-on or hardware release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_d_r    <= 1'b0;
      cold_boot_r <= 1'b0;
    end else begin
      boot_d_r    <= dom_n[1];
      cold_boot_r <= dom_n[1] & ~boot_d_r;
    end
  end

  assign cold_boot = cold_boot_r;

  // APB slave, zero wait states
  assign wr       = psel & penable & pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;

  always_comb begin
    hit    = 1'b1;
    rd_val = WORD_RST;
    case (paddr)
      OFS_SYSCTRL: rd_val[SYS_SWRB_BIT] = swrb_r;
      OFS_PMUCTRL: rd_val[PMU_WAKE_BIT] = wake_en_r;
      OFS_PORPIN: begin
        rd_val[PIN_SEL_LSB +: PIN_SEL_W] = pin_sel_r;
        rd_val[PIN_POL_BIT]              = pin_pol_r;
      end
      OFS_PORTIME: rd_val[FACTOR_W-1:0] = por_fac_r;
      OFS_RSTSTAT: rd_val[2:0] = stat_r;
      OFS_GPDATA:  rd_val = gp_data_r;
      OFS_SCRATCH: rd_val = scratch_r;
      default:     hit = 1'b0;
    endcase
  end

  assign pslverr    = psel & penable & ~hit;
  assign prdata_nxt = setup_rd ? rd_val : prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= WORD_RST;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // Next values of all software registers
  always_comb begin
    pin_sel_nxt = pin_sel_r;
    pin_pol_nxt = pin_pol_r;
    por_fac_nxt = por_fac_r;
    gp_data_nxt = gp_data_r;
    wake_en_nxt = wake_en_r;
    scratch_nxt = scratch_r;
    // Self-clearing, so a reboot request cannot loop
    swrb_nxt    = 1'b0;
    if (wr) begin
      case (paddr)
        OFS_SYSCTRL: swrb_nxt = pwdata[SYS_SWRB_BIT];
        OFS_PMUCTRL: wake_en_nxt = pwdata[PMU_WAKE_BIT];
        OFS_PORPIN: begin
          pin_sel_nxt = pwdata[PIN_SEL_LSB +: PIN_SEL_W];
          pin_pol_nxt = pwdata[PIN_POL_BIT];
        end
        OFS_PORTIME: por_fac_nxt = pwdata[FACTOR_W-1:0];
        OFS_GPDATA:  gp_data_nxt = pwdata;
        OFS_SCRATCH: scratch_nxt = pwdata;
        default: begin
        end
      endcase
    end
    if (ev[0]) begin
      stat_nxt = 3'h1 << STAT_POR_BIT;
    end else if (ev[1]) begin
      stat_nxt = 3'h1 << STAT_HW_BIT;
    end else if (ev[2]) begin
      stat_nxt = 3'h1 << STAT_SW_BIT;
    end else if (wr && paddr == OFS_RSTSTAT) begin
      stat_nxt = stat_r & ~pwdata[2:0];
    end else begin
      stat_nxt = stat_r;
    end
  end

  always_ff @(posedge pclk or negedge dom_n[0]) begin
    if (!dom_n[0]) begin
      pin_sel_r <= PINSEL_RST;
      pin_pol_r <= 1'b0;
      por_fac_r <= PORTIME_RST;
      gp_data_r <= WORD_RST;
      stat_r    <= STAT_RST;
    end else begin
      pin_sel_r <= pin_sel_nxt;
      pin_pol_r <= pin_pol_nxt;
      por_fac_r <= por_fac_nxt;
      gp_data_r <= gp_data_nxt;
      stat_r    <= stat_nxt;
    end
  end

  always_ff @(posedge pclk or negedge dom_n[1]) begin
    if (!dom_n[1]) begin
      swrb_r    <= 1'b0;
      wake_en_r <= 1'b0;
    end else begin
      swrb_r    <= swrb_nxt;
      wake_en_r <= wake_en_nxt;
    end
  end

  always_ff @(posedge pclk or negedge dom_n[2]) begin
    if (!dom_n[2]) begin
      scratch_r <= WORD_RST;
    end else begin
      scratch_r <= scratch_nxt;
    end
  end

  a_por_expiry: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_exp |=> act_r[0] ##1 !dom_n[0])
    else $error("expiry did not raise power-on reset");

  a_short_hw: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_short |=> act_r[1] ##2 (!dom_n[1] && !dom_n[2]))
    else $error("short press did not raise hardware reset");

  a_sw_or: assert property (@(posedge pclk) disable iff (!presetn)
    (swrb_r || cpu_sys_reset_req) |=> act_r[2])
    else $error("software line not raised");

  a_supply_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !supply_ok |-> !dom_n[0] && !dom_n[1] && !dom_n[2])
    else $error("domain released while supply low");

  a_wake_boot: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_from_sleep && wake_en_r) |=> act_r[1])
    else $error("wake did not raise hardware reset");

  a_cold_boot: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dom_n[1]) |=> cold_boot ##1 !cold_boot)
    else $error("cold boot pulse missing");

  a_por_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (dom_n[0] && !dom_n[1] && !wr) |=> $stable(por_fac_r) && $stable(gp_data_r))
    else $error("power-on group changed by other reset");

  a_hw_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (dom_n[1] && !dom_n[2] && !wr) |=> $stable(wake_en_r))
    else $error("hardware group changed by software reset");

  a_nested: assert property (@(posedge pclk) disable iff (!presetn)
    dom_n[2] |-> dom_n[1] && dom_n[0])
    else $error("reset domains not nested");

  a_sync_rel: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dom_n[1]) |-> !act_r[1] && !$past(act_r[1]))
    else $error("release not two cycles after request end");

  a_one_cause: assert property (@(posedge pclk) disable iff (!presetn)
    (ev[1] && !ev[0]) |=> (stat_r == 3'h2))
    else $error("hardware cause not latched alone");

  a_cause_hot: assert property (@(posedge pclk) disable iff (!dom_n[0])
    $onehot0(stat_r))
    else $error("more than one cause flag set");

endmodule : rgd_top

// ==== verification/rgd_ext_model.sv ====
// Far side model: reset button, supply monitors, CPU request and wake source
module rgd_ext_model (
  input  wire logic pclk,
  output logic      port0_pin0,
  output logic      cpu_sys_reset_req,
  output logic      wake_from_sleep,
  output logic      vdd_ok,
  output logic      vbat_high_ok,
  output logic      vbat_low_ok
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pad has a pull-down, so released reads low
  initial begin
    port0_pin0 = 1'b0;
    cpu_sys_reset_req = 1'b0;
    wake_from_sleep = 1'b0;
    vdd_ok = 1'b1;
    vbat_high_ok = 1'b1;
    vbat_low_ok = 1'b1;
  end

  // high level is a press; release falls to the pull-down
  task automatic press(input int n, input logic lvl);
    @(posedge pclk);
    port0_pin0 <= lvl;
    repeat (n) @(posedge pclk);
    port0_pin0 <= 1'b0;
  endtask : press

  task automatic cpu_req(input int n, input logic lvl);
    @(posedge pclk);
    cpu_sys_reset_req <= lvl;
    repeat (n) @(posedge pclk);
    cpu_sys_reset_req <= 1'b0;
  endtask : cpu_req

  task automatic wake(input logic lvl);
    @(posedge pclk);
    wake_from_sleep <= lvl;
    @(posedge pclk);
    wake_from_sleep <= 1'b0;
  endtask : wake

  // Each monitor has its own bit, so one can drop alone
  task automatic supply(input logic [2:0] v);
    @(posedge pclk);
    vdd_ok <= v[0];
    vbat_high_ok <= v[1];
    vbat_low_ok <= v[2];
  endtask : supply
endmodule : rgd_ext_model

// ==== verification/tb_rgd_top.sv ====
// Self-checking bench for the reset generation block
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_rgd_top;
  import rgd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} rgd_row_t;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, port0_pin0, cpu_sys_reset_req;
  logic        wake_from_sleep, vdd_ok, vbat_high_ok, vbat_low_ok;
  logic        rst_por_n, rst_hw_n, rst_all_n, cold_boot, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] gpio_in;
  int          fail_count, check_count, n_por, n_hw, n_all, n_boot;
  rgd_row_t    rows [12] = '{
    '{0, OFS_SYSCTRL, 0, 0, 0}, '{0, OFS_PMUCTRL, 0, 0, 0}, '{0, OFS_PORPIN, 0, 0, 0},
    '{0, OFS_PORTIME, 0, 32'h18, 0}, '{0, OFS_RSTSTAT, 0, 1, 0}, '{0, OFS_GPDATA, 0, 0, 0},
    '{0, 8'h1C, 0, 0, 1}, '{1, OFS_SCRATCH, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 0},
    '{1, OFS_GPDATA, 32'h1234_5678, 32'h1234_5678, 0}, '{1, OFS_PORTIME, '1, 32'h7F, 0},
    '{1, OFS_PORPIN, '1, 32'h1F, 0}, '{1, OFS_RSTSTAT, 1, 0, 0}};

  always #5 pclk = ~pclk;
  always @(negedge rst_por_n) n_por++;
  always @(negedge rst_hw_n) n_hw++;
  always @(negedge rst_all_n) n_all++;
  always @(posedge pclk) if (cold_boot === 1'b1) n_boot++;

  rgd_ext_model ext_inst (.pclk(pclk), .port0_pin0(port0_pin0),
    .cpu_sys_reset_req(cpu_sys_reset_req), .wake_from_sleep(wake_from_sleep),
    .vdd_ok(vdd_ok), .vbat_high_ok(vbat_high_ok), .vbat_low_ok(vbat_low_ok));
  rgd_top #(.POR_UNIT(4), .RC_DIV(2)) rgd_top_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vdd_ok(vdd_ok),
    .vbat_high_ok(vbat_high_ok), .vbat_low_ok(vbat_low_ok), .port0_pin0(port0_pin0),
    .gpio_in(gpio_in), .cpu_sys_reset_req(cpu_sys_reset_req),
    .wake_from_sleep(wake_from_sleep), .rst_por_n(rst_por_n), .rst_hw_n(rst_hw_n),
    .rst_all_n(rst_all_n), .cold_boot(cold_boot));

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50) begin
      fail_count++;
      conclude();
    end
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd)
  endtask : rdchk

  task automatic arm();
    apb(1'b1, OFS_RSTSTAT, 32'h7);
    n_por = 0;
    n_hw = 0;
    n_all = 0;
    n_boot = 0;
  endtask : arm

  // Waits out any reset in flight, then checks which lines fell
  task automatic evchk(input int p, input int h, input int a, input int b,
                       input logic [31:0] c);
    int i;
    repeat (4) @(posedge pclk);
    for (i = 0; i < 3000; i++) begin
      @(posedge pclk);
      if (rst_all_n === 1'b1 && rst_hw_n === 1'b1 && rst_por_n === 1'b1) break;
    end
    if (i == 3000) begin
      fail_count++;
      conclude();
    end
    repeat (4) @(posedge pclk);
    `CHK("por falls", p, n_por)
    `CHK("hw falls", h, n_hw)
    `CHK("all falls", a, n_all)
    `CHK("cold boots", b, n_boot)
    rdchk(OFS_RSTSTAT, c);
  endtask : evchk

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gpio_in = 12'h000;
    repeat (8) @(posedge pclk);
    `CHK("lines in reset", 4'h0, {rst_por_n, rst_hw_n, rst_all_n, cold_boot})
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    `CHK("lines released", 3'h7, {rst_por_n, rst_hw_n, rst_all_n})
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].a, rows[k].d);
      `CHK("pslverr", rows[k].x, er)
      if (rows[k].w) rdchk(rows[k].a, rows[k].e);
      else `CHK("row read", rows[k].e, rd)
    end
    apb(1'b1, 8'h1C, 32'h0);
    `CHK("unmapped write", 1'b1, er)
    // Short press: hardware reset only
    apb(1'b1, OFS_PORTIME, 32'h2);
    apb(1'b1, OFS_PMUCTRL, 32'h1);
    arm();
    ext_inst.press(5, 1'b1);
    evchk(0, 1, 1, 1, 32'h2);
    rdchk(OFS_SCRATCH, 32'h0);
    rdchk(OFS_GPDATA, 32'h1234_5678);
    rdchk(OFS_PORTIME, 32'h2);
    rdchk(OFS_PMUCTRL, 32'h0);
    // Software bit and CPU request
    apb(1'b1, OFS_PMUCTRL, 32'h1);
    apb(1'b1, OFS_SCRATCH, 32'h5);
    arm();
    apb(1'b1, OFS_SYSCTRL, 32'h1);
    evchk(0, 0, 1, 0, 32'h4);
    rdchk(OFS_PMUCTRL, 32'h1);
    rdchk(OFS_SCRATCH, 32'h0);
    rdchk(OFS_SYSCTRL, 32'h0);
    arm();
    ext_inst.cpu_req(3, 1'b1);
    evchk(0, 0, 1, 0, 32'h4);
    // Wake with and without the wake enable bit
    arm();
    ext_inst.wake(1'b1);
    evchk(0, 1, 1, 1, 32'h2);
    arm();
    ext_inst.wake(1'b1);
    evchk(0, 0, 0, 0, 32'h0);
    // Long press held well past a second full delay expires once
    arm();
    ext_inst.press(300, 1'b1);
    evchk(1, 1, 1, 1, 32'h1);
    rdchk(OFS_GPDATA, 32'h0);
    rdchk(OFS_PORTIME, 32'h18);
    // GPIO source, both polarities
    for (int p = 0; p < 2; p++) begin
      gpio_in <= p ? 12'h000 : 12'hFFF;
      apb(1'b1, OFS_PORTIME, 32'h2);
      apb(1'b1, OFS_PORPIN, p ? 32'h13 : 32'h05);
      arm();
      gpio_in[p ? 3 : 5] <= p[0];
      repeat (40) @(posedge pclk);
      gpio_in[p ? 3 : 5] <= ~p[0];
      evchk(1, 1, 1, 1, 32'h1);
    end
    // Early release clears the count; index zero is off
    apb(1'b1, OFS_PORTIME, 32'h2);
    apb(1'b1, OFS_PORPIN, 32'h13);
    arm();
    for (int r = 0; r < 2; r++) begin
      gpio_in[3] <= 1'b1;
      repeat (10) @(posedge pclk);
      gpio_in[3] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    evchk(0, 0, 0, 0, 32'h0);
    apb(1'b1, OFS_PORPIN, 32'h10);
    gpio_in[0] <= 1'b1;
    repeat (40) @(posedge pclk);
    gpio_in[0] <= 1'b0;
    evchk(0, 0, 0, 0, 32'h0);
    // Any one supply monitor dropping holds every line in power-on reset
    for (int s = 0; s < 3; s++) begin
      arm();
      ext_inst.supply(~(3'h1 << s));
      repeat (5) @(posedge pclk);
      `CHK("por during drop", 1'b0, rst_por_n)
      ext_inst.supply(3'h7);
      evchk(1, 1, 1, 1, 32'h1);
    end
    conclude();
  end
endmodule : tb_rgd_top
